// >>> src/wdt_pkg.sv
// Constants shared by the watchdog / interval timer block.
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [19:0] WDT_IDX_CSR = 20'hFFF8C;
  localparam logic [19:0] WDT_IDX_CNT_RD = 20'hFFF8D;
  localparam logic [19:0] WDT_IDX_RST_WR = 20'hFFF8E;
  localparam logic [19:0] WDT_IDX_RST_RD = 20'hFFF8F;
  localparam logic [19:0] WDT_IDX_IRQ_STAT = 20'hFFF90;
  localparam logic [19:0] WDT_IDX_IRQ_MASK = 20'hFFF91;

  // Password bytes carried in the upper byte of a guarded word write.
  localparam logic [7:0] WDT_PWD_CNT = 8'h5A;
  localparam logic [7:0] WDT_PWD_CSR = 8'hA5;

  ////////////////////////////////////////////////////////////////////////////
  // Control/status field positions and reset values.
  localparam int WDT_CSR_OVF = 7;
  localparam int WDT_CSR_MODE = 6;
  localparam int WDT_CSR_RUN = 5;
  localparam logic [1:0] WDT_CSR_FIXED = 2'h3;
  localparam logic [7:0] WDT_CSR_RST = 8'h18;
  localparam logic [7:0] WDT_CNT_RST = 8'h00;
  localparam logic [7:0] WDT_CNT_TOP = 8'hFF;
  localparam int WDT_RESET_CONTROL_STATUS_FLAG = 7;
  localparam int WDT_RESET_CONTROL_STATUS_OE = 6;
  localparam logic [5:0] WDT_RESET_CONTROL_STATUS_FIXED = 6'h3F;
  localparam logic [7:0] WDT_RESET_CONTROL_STATUS_RST = 8'h3F;

  // Interrupt status and mask layout.
  localparam int WDT_IRQ_OVF = 0;
  localparam int WDT_IRQ_WDRST = 1;
  localparam logic [1:0] WDT_IRQ_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse lengths in clock states, and the loads of their counters.
  localparam int WDT_CHIP_RST_STATES = 518;
  localparam int WDT_EXT_RST_STATES = 132;
  localparam logic [9:0] WDT_CHIP_RST_LOAD = 10'(WDT_CHIP_RST_STATES - 1);
  localparam logic [9:0] WDT_EXT_RST_LOAD = 10'(WDT_EXT_RST_STATES - 1);

  // Prescaler tap masks, divide ratio minus one, by clock select code.
  localparam logic [11:0] WDT_TAP_MASK [8] = '{
    12'h001, 12'h01F, 12'h03F, 12'h07F,
    12'h0FF, 12'h1FF, 12'h7FF, 12'hFFF
  };

endpackage

// >>> src/wdt_prescaler.sv
// Free-running system clock prescaler with eight selectable taps.
`timescale 1ns/1ps
`default_nettype none

module wdt_prescaler (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [11:0] div_ff;
  logic [11:0] nxt_div;
  logic [11:0] tap_mask;

  ////////////////////////////////////////////////////////////////////////////
  // One tick every 2^n clocks: the low n bits of the divider are all ones.
  assign nxt_div = div_ff + 12'h001;
  assign tap_mask = wdt_pkg::WDT_TAP_MASK[sel];
  assign tick = ((div_ff & tap_mask) == tap_mask);

  // The divider never stops, so a tap change may give one short period.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 12'h000;
    end else if (ce) begin
      div_ff <= nxt_div;
    end
  end

endmodule
`default_nettype wire

// >>> src/wdt_timer.sv
// Watchdog / interval timer with a classic Wishbone register slave.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module wdt_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [21:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standby_entry,
  output logic chip_reset,
  output logic reset_out_n_o,
  output logic reset_out_n_oe,
  output logic interval_overflow_irq,
  output logic irq
);

  logic ack_ff;
  logic [31:0] dat_ff;
  logic ovf_ff;
  logic mode_ff;
  logic run_ff;
  logic [2:0] cks_ff;
  logic ovf_armed_ff;
  logic [7:0] cnt_ff;
  logic wrst_ff;
  logic rstoe_ff;
  logic chip_rst_ff;
  logic [9:0] chip_cnt_ff;
  logic oe_ff;
  logic [9:0] ext_cnt_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic interval_overflow_irq_ff;
  logic irq_ff;
  logic tick;

  logic nxt_ovf;
  logic nxt_mode;
  logic nxt_run;
  logic [2:0] nxt_cks;
  logic nxt_armed;
  logic [7:0] nxt_cnt;
  logic [1:0] nxt_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. One access is taken per request; ack follows one edge later.
  wire acc = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr = acc && wb_we_i;
  wire rd = acc && !wb_we_i;
  wire [19:0] idx = wb_adr_i[21:2];
  wire word_wr = wr && (wb_sel_i[1:0] == 2'h3);
  wire [7:0] pwd = wb_dat_i[15:8];
  wire [7:0] wd = wb_dat_i[7:0];
  wire at_csr = (idx == wdt_pkg::WDT_IDX_CSR);
  wire at_cnt = (idx == wdt_pkg::WDT_IDX_CNT_RD);
  wire at_rstw = (idx == wdt_pkg::WDT_IDX_RST_WR);
  wire at_rstr = (idx == wdt_pkg::WDT_IDX_RST_RD);
  wire at_stat = (idx == wdt_pkg::WDT_IDX_IRQ_STAT);
  wire at_mask = (idx == wdt_pkg::WDT_IDX_IRQ_MASK);

  // Guarded writes: the upper byte picks the target, the lower is data.
  wire pwd_cnt = (pwd == wdt_pkg::WDT_PWD_CNT);
  wire pwd_csr = (pwd == wdt_pkg::WDT_PWD_CSR);
  wire wr_cnt = word_wr && at_csr && pwd_cnt;
  wire wr_csr = word_wr && at_csr && pwd_csr;
  wire wr_rst_clr = word_wr && at_rstw && pwd_csr && (wd == 8'h00);
  wire wr_rst_oe = word_wr && at_rstw && pwd_cnt;
  wire wr_stat = wr && at_stat && wb_sel_i[0];
  wire wr_mask = wr && at_mask && wb_sel_i[0];
  wire rd_csr = rd && at_csr;

  ////////////////////////////////////////////////////////////////////////////
  // Count events. An increment is lost when a counter write lands on it.
  wire inc = run_ff && tick && !chip_rst_ff;
  wire at_top = (cnt_ff == wdt_pkg::WDT_CNT_TOP);
  wire ovf_evt = inc && at_top && !wr_cnt;
  wire wd_evt = ovf_evt && mode_ff;
  wire ovf_clr = wr_csr && !wd[7] && ovf_armed_ff;

  // Read views; unused upper bits and unmapped indices read as zero.
  wire [7:0] csr_view = {ovf_ff, mode_ff, run_ff,
                         wdt_pkg::WDT_CSR_FIXED, cks_ff};
  wire [7:0] rst_view = {wrst_ff, rstoe_ff, wdt_pkg::WDT_RESET_CONTROL_STATUS_FIXED};
  wire [7:0] rd_mux = at_csr ? csr_view :
                      at_cnt ? cnt_ff :
                      at_rstr ? rst_view :
                      at_stat ? {6'h00, stat_ff} :
                      at_mask ? {6'h00, mask_ff} : 8'h00;

  wdt_prescaler u_presc (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .sel(cks_ff),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control/status next state. Standby and the internal reset both clear
  // the upper control bits; only the internal reset clears the select.
  always_comb begin
    nxt_ovf = ovf_evt || (ovf_ff && !ovf_clr);
    nxt_mode = wr_csr ? wd[wdt_pkg::WDT_CSR_MODE] : mode_ff;
    nxt_run = wr_csr ? wd[wdt_pkg::WDT_CSR_RUN] : run_ff;
    nxt_cks = wr_csr ? wd[2:0] : cks_ff;
    nxt_armed = (ovf_armed_ff || (rd_csr && ovf_ff)) && !ovf_clr;
    if (standby_entry || chip_rst_ff) begin
      nxt_ovf = 1'b0;
      nxt_mode = 1'b0;
      nxt_run = 1'b0;
      nxt_armed = 1'b0;
    end
    if (chip_rst_ff) begin
      nxt_cks = 3'h0;
    end
  end

  // Counter next value. A halted counter is forced to zero, so a counter
  // write while halted has no lasting effect.
  always_comb begin
    if (chip_rst_ff || !run_ff) begin
      nxt_cnt = wdt_pkg::WDT_CNT_RST;
    end else if (wr_cnt) begin
      nxt_cnt = wd;
    end else if (inc) begin
      nxt_cnt = cnt_ff + 8'h01;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // Sticky interrupt status: a set in the clearing cycle wins.
  assign nxt_stat[wdt_pkg::WDT_IRQ_OVF] = ovf_evt ||
    (stat_ff[wdt_pkg::WDT_IRQ_OVF] && !(wr_stat && wd[wdt_pkg::WDT_IRQ_OVF]));
  assign nxt_stat[wdt_pkg::WDT_IRQ_WDRST] = wd_evt ||
    (stat_ff[wdt_pkg::WDT_IRQ_WDRST] &&
     !(wr_stat && wd[wdt_pkg::WDT_IRQ_WDRST]));

  ////////////////////////////////////////////////////////////////////////////
  // Bus response registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff <= acc;
      dat_ff <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Control/status and counter state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ff <= wdt_pkg::WDT_CSR_RST[wdt_pkg::WDT_CSR_OVF];
      mode_ff <= wdt_pkg::WDT_CSR_RST[wdt_pkg::WDT_CSR_MODE];
      run_ff <= wdt_pkg::WDT_CSR_RST[wdt_pkg::WDT_CSR_RUN];
      cks_ff <= wdt_pkg::WDT_CSR_RST[2:0];
      ovf_armed_ff <= 1'b0;
      cnt_ff <= wdt_pkg::WDT_CNT_RST;
    end else if (ce) begin
      ovf_ff <= nxt_ovf;
      mode_ff <= nxt_mode;
      run_ff <= nxt_run;
      cks_ff <= nxt_cks;
      ovf_armed_ff <= nxt_armed;
      cnt_ff <= nxt_cnt;
    end
  end

  // Reset status flag survives the internal reset, like its enable bit.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrst_ff <= wdt_pkg::WDT_RESET_CONTROL_STATUS_RST[wdt_pkg::WDT_RESET_CONTROL_STATUS_FLAG];
      rstoe_ff <= 1'b0;
    end else if (ce) begin
      wrst_ff <= wd_evt || (wrst_ff && !wr_rst_clr);
      rstoe_ff <= wr_rst_oe ? wd[wdt_pkg::WDT_RESET_CONTROL_STATUS_OE] : rstoe_ff;
    end
  end

  // Internal chip reset: high for a fixed number of states from overflow.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chip_rst_ff <= 1'b0;
      chip_cnt_ff <= 10'h000;
    end else if (ce && wd_evt) begin
      chip_rst_ff <= 1'b1;
      chip_cnt_ff <= wdt_pkg::WDT_CHIP_RST_LOAD;
    end else if (ce && chip_rst_ff) begin
      chip_rst_ff <= (chip_cnt_ff != 10'h000);
      chip_cnt_ff <= chip_cnt_ff - 10'h001;
    end
  end

  // External reset pin: open drain, pulled low only when enabled.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_ff <= 1'b0;
      ext_cnt_ff <= 10'h000;
    end else if (ce && wd_evt) begin
      oe_ff <= rstoe_ff;
      ext_cnt_ff <= wdt_pkg::WDT_EXT_RST_LOAD;
    end else if (ce && oe_ff) begin
      oe_ff <= (ext_cnt_ff != 10'h000);
      ext_cnt_ff <= ext_cnt_ff - 10'h001;
    end
  end

  // Interrupt status, mask and the two request outputs.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= wdt_pkg::WDT_IRQ_RST;
      mask_ff <= wdt_pkg::WDT_IRQ_RST;
      interval_overflow_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      stat_ff <= nxt_stat;
      mask_ff <= wr_mask ? wd[1:0] : mask_ff;
      interval_overflow_irq_ff <= nxt_ovf && !nxt_mode;
      irq_ff <= |(nxt_stat & (wr_mask ? wd[1:0] : mask_ff));
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign chip_reset = chip_rst_ff;
  assign reset_out_n_o = 1'b0; // Open drain: only ever pulls low.
  assign reset_out_n_oe = oe_ff;
  assign interval_overflow_irq = interval_overflow_irq_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks kept beside the logic.
  AST_COUNT_UP: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && inc && !wr_cnt && !at_top |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("counter did not advance on its tick");

  AST_OVF_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ovf_evt && !standby_entry |=> ovf_ff && cnt_ff == 8'h00)
    else $error("wrap did not set overflow flag");

  AST_OVF_NOCLR: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ovf_ff && !ovf_armed_ff && !standby_entry && !chip_rst_ff
    |=> ovf_ff)
    else $error("overflow flag cleared without prior read");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
    interval_overflow_irq == (ovf_ff && !mode_ff))
    else $error("interval request differs from flag");

  AST_WD_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && wd_evt |=> chip_reset && chip_cnt_ff == 10'h205)
    else $error("watchdog overflow gave no chip reset");

  AST_HOLD_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !run_ff |=> cnt_ff == 8'h00)
    else $error("halted counter not at zero");

  AST_FIXED_ONES: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rd && at_csr |=> wb_ack_o && wb_dat_o[4:3] == 2'h3)
    else $error("fixed control bits not read as one");

  AST_STANDBY: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && standby_entry && !chip_rst_ff && !wr_csr
    |=> !run_ff && !mode_ff && !ovf_ff && cks_ff == $past(cks_ff))
    else $error("standby did not clear upper control bits");

  AST_PIN_IN_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    reset_out_n_oe |-> chip_reset)
    else $error("reset pin driven outside chip reset");

  AST_BYTE_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && wr && at_csr && wb_sel_i[1:0] != 2'h3 && !standby_entry
    && !chip_rst_ff |=> mode_ff == $past(mode_ff))
    else $error("byte write changed control register");

  AST_RESET_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && chip_rst_ff && chip_cnt_ff == 10'h000 && !wd_evt
    |=> !chip_reset)
    else $error("internal reset outlasted its count");

  AST_WRITE_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && wr_cnt && run_ff && !chip_rst_ff |=> cnt_ff == $past(wd))
    else $error("counter write lost to increment");

endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the watchdog / interval timer block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic mclk = 1'b0;
  logic rst_n, ce, cyc, stb, we, standby_entry;
  logic [21:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, wb_dat_o;
  logic wb_ack_o, chip_reset, reset_out_n_o, reset_out_n_oe;
  logic interval_overflow_irq, irq;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  integer seed = 90;
  logic [31:0] exp_q[$];
  int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  wdt_timer u_wdt_timer (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby_entry(standby_entry),
    .chip_reset(chip_reset), .reset_out_n_o(reset_out_n_o),
    .reset_out_n_oe(reset_out_n_oe),
    .interval_overflow_irq(interval_overflow_irq), .irq(irq));

  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count the outcome.
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic [19:0] idx, input logic wr_en,
                     input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    adr <= {idx, 2'b00};
    sel <= be;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk("bus ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Guarded word write: password in the upper byte, data in the lower.
  task automatic wr(input logic [19:0] idx, input logic [7:0] pw,
                    input logic [7:0] d, input logic [3:0] be = 4'hF);
    bus(idx, 1'b1, {pw, d}, be);
  endtask

  // Reads note their expected byte for the monitor before the request.
  task automatic rd(input logic [19:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(idx, 1'b0, 16'h0000, 4'hF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read monitor: every read ack retires the oldest noted value.
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      if (exp_q.size() > 0)
        chk("read data", exp_q.pop_front(), wb_dat_o);
      else
        chk("read with no note", 32'h1, 32'h0);
    end
  end

  // Cut a hang short; the longest test needs about 22000 cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      chk("run time limit", 32'h1, 32'h0);
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    int m;
    logic [7:0] b;
    rst_n = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 22'h000000;
    sel = 4'h0;
    dat_i = 32'h00000000;
    standby_entry = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(wdt_pkg::WDT_IDX_CSR, 8'h18);
    rd(wdt_pkg::WDT_IDX_CNT_RD, 8'h00);
    rd(wdt_pkg::WDT_IDX_RST_RD, 8'h3F);
    rd(wdt_pkg::WDT_IDX_IRQ_STAT, 8'h00);
    rd(wdt_pkg::WDT_IDX_IRQ_MASK, 8'h00);
    rd(20'hFFF92, 8'h00);
    // Byte writes and wrong passwords must leave the control untouched.
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'h27, 4'h1);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      if (b == wdt_pkg::WDT_PWD_CNT || b == wdt_pkg::WDT_PWD_CSR) b = 8'h00;
      wr(wdt_pkg::WDT_IDX_CSR, b, 8'h27);
    end
    rd(wdt_pkg::WDT_IDX_CSR, 8'h18);
    // Three ticks from H'FD to overflow at every divide ratio.
    for (int c = 0; c < 8; c++) begin
      wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'(8'h20 | c));
      rd(wdt_pkg::WDT_IDX_CSR, 8'(8'h38 | c));
      wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CNT, 8'hFD);
      n = 0;
      while (interval_overflow_irq !== 1'b1 && n < 13000) begin
        @(posedge mclk);
        n++;
      end
      chk("overflow delay", 32'h1,
          32'(n >= 2 * divs[c] - 3 && n <= 3 * divs[c] + 3));
      rd(wdt_pkg::WDT_IDX_CSR, 8'(8'hB8 | c));
      wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'(8'hA0 | c));
      rd(wdt_pkg::WDT_IDX_CSR, 8'(8'hB8 | c));
    end
    // Interrupt stays masked until enabled, then clears by writing one.
    chk("irq masked", 32'h0, irq);
    wr(wdt_pkg::WDT_IDX_IRQ_MASK, 8'h00, 8'h01);
    @(posedge mclk);
    chk("irq unmasked", 32'h1, irq);
    wr(wdt_pkg::WDT_IDX_IRQ_STAT, 8'h00, 8'h01);
    @(posedge mclk);
    chk("irq cleared", 32'h0, irq);
    chk("interval request held", 32'h1, interval_overflow_irq);
    rd(wdt_pkg::WDT_IDX_CSR, 8'hBF);
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'h03);
    @(posedge mclk);
    chk("interval request dropped", 32'h0, interval_overflow_irq);
    // A counter load while halted is lost; the counter stays at zero.
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CNT, 8'($random(seed)));
    rd(wdt_pkg::WDT_IDX_CNT_RD, 8'h00);
    // Standby clears mode, run and flag but keeps the clock select.
    // The run bit is already low when standby comes, as software must.
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'h43);
    rd(wdt_pkg::WDT_IDX_CSR, 8'h5B);
    standby_entry <= 1'b1;
    @(posedge mclk);
    standby_entry <= 1'b0;
    rd(wdt_pkg::WDT_IDX_CSR, 8'h1B);
    rd(wdt_pkg::WDT_IDX_CNT_RD, 8'h00);
    // Watchdog mode with the reset pin enabled; timely refreshes first.
    wr(wdt_pkg::WDT_IDX_RST_WR, wdt_pkg::WDT_PWD_CNT, 8'h40);
    rd(wdt_pkg::WDT_IDX_RST_RD, 8'h7F);
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CSR, 8'h60);
    for (int i = 0; i < 3; i++) begin
      wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CNT, 8'h00);
      repeat (200) @(posedge mclk);
      chk("refreshed watchdog quiet", 32'h0, chip_reset);
    end
    wr(wdt_pkg::WDT_IDX_CSR, wdt_pkg::WDT_PWD_CNT, 8'hFD);
    n = 0;
    while (chip_reset !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    m = 0;
    while (chip_reset === 1'b1 && n < 1000) begin
      if (reset_out_n_oe === 1'b1 && reset_out_n_o === 1'b0) m++;
      @(posedge mclk);
      n++;
    end
    chk("chip reset length", 32'h206, 32'(n));
    chk("reset pin low length", 32'h84, 32'(m));
    rd(wdt_pkg::WDT_IDX_RST_RD, 8'hFF);
    rd(wdt_pkg::WDT_IDX_CSR, 8'h18);
    rd(wdt_pkg::WDT_IDX_IRQ_STAT, 8'h03);
    wr(wdt_pkg::WDT_IDX_RST_WR, wdt_pkg::WDT_PWD_CSR, 8'h00);
    rd(wdt_pkg::WDT_IDX_RST_RD, 8'h7F);
    repeat (2) @(posedge mclk);
    print_verdict();
  end
endmodule

`default_nettype wire
